// file: design/ocdsp_map.svh
// Purpose: named constants of the octal converter serial input port
// Assumes: included by bare name from every design file that needs it
// Notes:   widths, counts and reset values only, no logic
`ifndef OCDSP_MAP_SVH
`define OCDSP_MAP_SVH

// word length of the input shift register
`define OCDSP_WORD_W      16
// falling edges needed before a frame rise commits the word
`define OCDSP_UPDATE_CNT  16
// a frame rise before this many falling edges is an abort
`define OCDSP_ABORT_CNT   15
// reset value of the shift register and the committed word
`define OCDSP_WORD_RST    16'h0000
// reset value of the serial chain output bit
`define OCDSP_CHAIN_RST   1'b0

`endif

// file: design/ocdsp_pkg.sv
// Purpose: types shared by the serial input port modules
// Assumes: nothing beyond the constants header
// Notes:   the frame tracker is a two-state machine
package ocdsp_pkg;

  // frame tracker states
  typedef enum logic {
    OCDSP_IDLE,
    OCDSP_SHIFT
  } ocdsp_state_t;

endpackage : ocdsp_pkg

// file: design/ocdsp_sh_if.sv
// Purpose: link between the frame tracker and the shift register
// Assumes: both ends run on the same clock
// Notes:   ctl drives the strobes, sr returns the word and its tail bit
`timescale 1ns/1ps

interface ocdsp_sh_if #(
  parameter int WORD_W = 16
);
  logic              shift_en;
  logic              clr;
  logic              din;
  logic [WORD_W-1:0] word;
  logic              tail;

  modport ctl (output shift_en, output clr, output din, input word, input tail);
  modport sr  (input shift_en, input clr, input din, output word, output tail);
endinterface : ocdsp_sh_if

// file: design/ocdsp_shift.sv
// Purpose: input shift register of the serial port, msb first
// Assumes: shift_en is a one-cycle strobe per serial clock falling edge
// Notes:   tail is the bit about to leave the far end of the register
`timescale 1ns/1ps
`include "ocdsp_map.svh"

module ocdsp_shift
  import ocdsp_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input  wire logic mclk_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  ocdsp_sh_if.sr    sh
);

  logic [WORD_W-1:0] sr_reg;
  logic [WORD_W-1:0] sr_next;

  // clear wins over shift so a new frame starts from a known word
  assign sr_next = sh.clr ? WORD_W'(`OCDSP_WORD_RST) :
                   sh.shift_en ? {sr_reg[WORD_W-2:0], sh.din} : sr_reg;

  // register, frozen while the clock enable is low
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sr_reg <= WORD_W'(`OCDSP_WORD_RST);
    end else if (ce_in) begin
      sr_reg <= sr_next;
    end
  end

  assign sh.word = sr_reg;
  assign sh.tail = sr_reg[WORD_W-1];

endmodule : ocdsp_shift

// file: design/ocdsp_port.sv
// Purpose: serial input port of an eight-channel converter, sampled on mclk_in
// Assumes: serial clock at most mclk_in/4; all three pins are asynchronous
// Notes:   update_out and abort_out are one-cycle pulses at the frame end
`timescale 1ns/1ps
`include "ocdsp_map.svh"

module ocdsp_port
  import ocdsp_pkg::*;
#(
  parameter int WORD_W = `OCDSP_WORD_W
) (
  input  wire logic              mclk_in,
  input  wire logic              srst_in,
  input  wire logic              ce_in,
  input  wire logic              frame_sel_n_in,
  input  wire logic              sclk_in,
  input  wire logic              sdata_in,
  output logic                   chain_data_out,
  output logic [WORD_W-1:0]      word_out,
  output logic                   update_out,
  output logic                   abort_out
);

  localparam int CW = $clog2(WORD_W + 2);
  localparam logic [CW-1:0] CNT_UPD = CW'(`OCDSP_UPDATE_CNT);
  localparam logic [CW-1:0] CNT_ABT = CW'(`OCDSP_ABORT_CNT);
  localparam logic [CW-1:0] CNT_MAX = CW'(`OCDSP_UPDATE_CNT + 1);

  ////////////////////////////////////////////////////////////////////////////
  // edge helpers

  function automatic logic fell(input logic prev, input logic now);
    return prev & ~now;
  endfunction : fell

  function automatic logic rose(input logic prev, input logic now);
    return ~prev & now;
  endfunction : rose

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second

  logic [2:0] frm_sync_reg;
  logic [2:0] clk_sync_reg;
  logic [1:0] dat_sync_reg;

  // idle levels at reset: frame high, serial clock high, data low
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      frm_sync_reg <= 3'h7;
      clk_sync_reg <= 3'h7;
      dat_sync_reg <= 2'h0;
    end else if (ce_in) begin
      frm_sync_reg <= {frm_sync_reg[1:0], frame_sel_n_in};
      clk_sync_reg <= {clk_sync_reg[1:0], sclk_in};
      dat_sync_reg <= {dat_sync_reg[0], sdata_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded events

  wire frm_fall;
  wire frm_rise;
  wire sclk_fall;
  wire sclk_rise;
  wire din_s;

  assign frm_fall  = fell(frm_sync_reg[2], frm_sync_reg[1]);
  assign frm_rise  = rose(frm_sync_reg[2], frm_sync_reg[1]);
  assign sclk_fall = fell(clk_sync_reg[2], clk_sync_reg[1]);
  assign sclk_rise = rose(clk_sync_reg[2], clk_sync_reg[1]);
  // data taken at the same stage as the clock edge, so setup stays aligned
  assign din_s     = dat_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // frame tracker state

  ocdsp_state_t      state_reg;
  ocdsp_state_t      state_next;
  logic [CW-1:0]     cnt_reg;
  logic [CW-1:0]     cnt_next;
  logic              chain_reg;
  logic              chain_next;
  logic [WORD_W-1:0] word_reg;
  logic [WORD_W-1:0] word_next;
  logic              upd_reg;
  logic              abt_reg;

  ocdsp_sh_if #(.WORD_W(WORD_W)) sh ();

  // qualifiers of the current frame
  wire in_frame;
  wire shift_now;
  wire full_word;
  wire early_rise;
  wire chain_live;
  wire frame_end;

  assign in_frame   = (state_reg == OCDSP_SHIFT);
  // a clock fall in the same sample as the frame rise is not taken
  assign shift_now  = in_frame & sclk_fall & ~frm_rise;
  assign full_word  = (cnt_reg >= CNT_UPD);
  // exactly fifteen falls is neither abort nor update: treated as abort
  assign early_rise = (cnt_reg <  CNT_UPD);
  // chain moves on the rise after a fall, so the next device takes it on its own fall
  assign chain_live = in_frame & sclk_rise & full_word;
  assign frame_end  = in_frame & frm_rise;

  // next state: a frame opens only on the frame select fall
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      OCDSP_IDLE: begin
        if (frm_fall) begin
          state_next = OCDSP_SHIFT;
        end
      end
      OCDSP_SHIFT: begin
        if (frm_rise) begin
          state_next = OCDSP_IDLE;
        end
      end
      default: begin
        state_next = OCDSP_IDLE;
      end
    endcase
  end

  // fall counter saturates just past one word, enough to see "more than"
  assign cnt_next = (state_reg == OCDSP_IDLE) ? '0 :
                    (shift_now && cnt_reg != CNT_MAX) ? cnt_reg + CW'(1) : cnt_reg;

  // chain shows the register end bit once sixteen falls are in, else low
  assign chain_next = !in_frame  ? `OCDSP_CHAIN_RST :
                      chain_live ? sh.tail : chain_reg;

  // committed word changes only on a complete frame
  assign word_next = (frame_end && full_word) ? sh.word : word_reg;

  // shift register strobes
  assign sh.shift_en = shift_now;
  assign sh.clr      = (state_reg == OCDSP_IDLE) & frm_fall;
  assign sh.din      = din_s;

  // all tracker flops freeze while the clock enable is low
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_reg <= OCDSP_IDLE;
      cnt_reg   <= '0;
      chain_reg <= `OCDSP_CHAIN_RST;
      word_reg  <= WORD_W'(`OCDSP_WORD_RST);
      upd_reg   <= 1'b0;
      abt_reg   <= 1'b0;
    end else if (ce_in) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      chain_reg <= chain_next;
      word_reg  <= word_next;
      upd_reg   <= frame_end & full_word;
      abt_reg   <= frame_end & early_rise;
    end
  end

  ocdsp_shift #(
    .WORD_W (WORD_W)
  ) u_shift (
    .mclk_in (mclk_in),
    .srst_in (srst_in),
    .ce_in   (ce_in),
    .sh      (sh)
  );

  // outputs straight from flops; chain pin is driven at all times
  assign chain_data_out = chain_reg;
  assign word_out       = word_reg;
  assign update_out     = upd_reg;
  assign abort_out      = abt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  shift_take_a: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    (ce_in && shift_now) |=> (sh.word[0] == $past(din_s))
                             && (sh.word[WORD_W-1:1] == $past(sh.word[WORD_W-2:0])))
    else $error("data bit not shifted on serial clock fall");

  update_commit_a: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    (ce_in && frame_end && cnt_reg >= CNT_UPD)
      |=> update_out && !abort_out && (word_out == $past(sh.word)))
    else $error("complete frame did not commit its word");

  abort_drop_a: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    (ce_in && frame_end && cnt_reg < CNT_ABT)
      |=> abort_out && !update_out && $stable(word_out))
    else $error("early frame rise changed the word");

  word_hold_a: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    !update_out |-> word_out == $past(word_out))
    else $error("word output moved without an update");

  idle_noshift_a: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    !in_frame |=> $stable(sh.word) || $past(sh.clr))
    else $error("shift register moved outside a frame");

  chain_quiet_a: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    ((ce_in && !in_frame) || (in_frame && cnt_reg < CNT_UPD)) |=> !chain_data_out)
    else $error("chain output active before sixteen falls");

  chain_tail_a: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    (ce_in && chain_live) |=> chain_data_out == $past(sh.tail))
    else $error("chain output is not the bit leaving the register");

  pulse_single_a: assert property (
    @(posedge mclk_in) disable iff (srst_in)
    update_out |-> !(update_out && abort_out) ##1 (!update_out || !ce_in))
    else $error("update pulse longer than one cycle");

endmodule : ocdsp_port

// file: testbench/ocdsp_host_model.sv
// Purpose: host serial controller that frames words into the converter port
// Assumes: driven from the bench clock, changes only at falling mclk edges
// Notes:   serial clock idles high; outside frames it moves only in stray pulses
`timescale 1ns/1ps

module ocdsp_host_model (
  input  wire logic mclk_in,
  output logic      frame_sel_n_out,
  output logic      sclk_out,
  output logic      sdata_out
);
  // idle pins: frame and clock high
  initial begin
    frame_sel_n_out = 1'b1;
    sclk_out        = 1'b1;
    sdata_out       = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // one frame of n falls, msb first; data stable 4 cycles around each fall
  task automatic send(input logic [31:0] bits, input int n);
    @(negedge mclk_in) frame_sel_n_out = 1'b0;
    repeat (4) @(negedge mclk_in);
    for (int i = 0; i < n; i++) begin
      sdata_out = bits[n-1-i];
      repeat (4) @(negedge mclk_in);
      sclk_out = 1'b0;
      repeat (4) @(negedge mclk_in);
      sclk_out = 1'b1;
    end
    repeat (4) @(negedge mclk_in);
    sdata_out       = ~sdata_out; // released line, no pull: not the last bit
    frame_sel_n_out = 1'b1;
    repeat (6) @(negedge mclk_in);
  endtask : send

  // clock pulses with frame high, which the port must ignore
  task automatic stray(input int k);
    repeat (k) begin
      repeat (4) @(negedge mclk_in);
      sclk_out  = 1'b0;
      sdata_out = ~sdata_out;
      repeat (4) @(negedge mclk_in);
      sclk_out = 1'b1;
    end
    repeat (6) @(negedge mclk_in);
  endtask : stray
endmodule : ocdsp_host_model

// file: testbench/ocdsp_port_tb.sv
// Purpose: self-checking bench of the serial port, two ports in a chain
// Assumes: host model drives pins at falling mclk edges
// Notes:   random frames of 0 to 32 falls mixed with corner cases
`timescale 1ns/1ps

module ocdsp_port_tb;
  logic        mclk_in     = 1'b0;
  logic        srst_in     = 1'b1;
  logic        ce_in       = 1'b1;
  logic        frame_n, sclk, sdata, chain_up, chain_dn;
  logic        upd_up, upd_dn, abt_up, abt_dn;
  logic [15:0] word_up, word_dn;
  logic [15:0] exp_up      = 16'h0000;
  logic [15:0] exp_dn      = 16'h0000;
  logic [31:0] seed        = 32'h0000_3D08;
  logic [31:0] bits;
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  int          n_upd       = 0;
  int          n_abt       = 0;
  int          n_dn        = 0;

  always #20 mclk_in = ~mclk_in;

  ocdsp_host_model host (.mclk_in(mclk_in), .frame_sel_n_out(frame_n),
    .sclk_out(sclk), .sdata_out(sdata));
  ocdsp_port uut (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce_in),
    .frame_sel_n_in(frame_n), .sclk_in(sclk), .sdata_in(sdata),
    .chain_data_out(chain_up), .word_out(word_up), .update_out(upd_up),
    .abort_out(abt_up));
  // chain output wired straight into the next data input
  ocdsp_port uut_dn (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce_in),
    .frame_sel_n_in(frame_n), .sclk_in(sclk), .sdata_in(chain_up),
    .chain_data_out(chain_dn), .word_out(word_dn), .update_out(upd_dn),
    .abort_out(abt_dn));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    xs = r ^ (r << 5);
  endfunction : xs

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // pulse counters; a pulse held two cycles counts twice
  always @(posedge mclk_in) begin
    cyc++;
    if (upd_up === 1'b1) n_upd++;
    if (abt_up === 1'b1) n_abt++;
    if (upd_dn === 1'b1) n_dn++;
    if (cyc > 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // one frame and its expected outcome at both chain positions
  task automatic frame(input logic [31:0] b, input int n);
    int          u0, a0, d0;
    logic [31:0] m;
    u0 = n_upd;
    a0 = n_abt;
    d0 = n_dn;
    m  = (n >= 32) ? 32'hFFFF_FFFF : ((32'h1 << n) - 32'h1);
    host.send(b, n);
    if (n >= 16) begin
      exp_up = b[15:0];
      exp_dn = 16'((b & m) >> 16);
    end
    chk(16'(n_upd - u0), (n >= 16) ? 16'h0001 : 16'h0000);
    chk(16'(n_abt - a0), (n < 16) ? 16'h0001 : 16'h0000);
    chk(16'(n_dn - d0), (n >= 16) ? 16'h0001 : 16'h0000);
    chk(word_up, exp_up);
    chk(word_dn, exp_dn);
    chk({15'h0000, chain_up}, 16'h0000);
  endtask : frame

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge mclk_in);
    srst_in = 1'b0;
    frame(32'hA5C3_0F1E, 32);
    frame(32'h0000_FFFF, 16);
    frame(32'h0000_7FFF, 15);
    frame(32'h0000_0000, 0);
    frame(32'h0000_0001, 1);
    frame(32'h0001_8001, 17);
    frame(32'h0000_0000, 16);
    host.stray(3);
    chk(16'(n_upd), 16'h0004);
    chk(word_up, exp_up);
    // a frame sent while the clock enable is low must leave no trace
    ce_in = 1'b0;
    host.send(32'h0000_5A5A, 16);
    ce_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk(16'(n_upd), 16'h0004);
    chk(16'(n_dn), 16'h0004);
    chk(16'(n_abt), 16'h0003);
    chk(word_up, exp_up);
    // mid-run reset with idle pins clears both committed words
    srst_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    srst_in = 1'b0;
    exp_up = 16'h0000;
    exp_dn = 16'h0000;
    chk(word_up, exp_up);
    chk(word_dn, exp_dn);
    repeat (30) begin
      seed = xs(seed);
      bits = seed;
      seed = xs(seed);
      frame(bits, int'(seed % 32'd33));
    end
    finish_test();
  end
endmodule : ocdsp_port_tb
